// >>> rsor_register_stack.sv
// 16x4 register stack with edge-loaded output register and 3-state enable
module rsor_register_stack
  import rsor_pkg::*;
#(
  parameter int unsigned DATA_W  = rsor_pkg::WORD_W,
  parameter int unsigned ADDR_BW = rsor_pkg::ADDR_W,
  parameter int unsigned WORDS   = rsor_pkg::DEPTH
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Host strobes, asynchronous to mclk; cs_n, we_n and oe_n active low, cp loads on its rising edge
  input  wire logic               cp,
  input  wire logic               cs_n,
  input  wire logic               we_n,
  input  wire logic               oe_n,
  // Host address and write data
  input  wire logic [ADDR_BW-1:0] word_select,
  input  wire logic [DATA_W-1:0]  write_data_in,
  // Three-state data outputs
  output logic      [DATA_W-1:0]  read_data_out,
  output logic      [DATA_W-1:0]  read_data_oe
);

  import rsor_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [CTRL_W-1:0]  ctrl_raw;
  logic [CTRL_W-1:0]  ctrl_s;
  logic [ADDR_BW-1:0] addr_s;
  logic [DATA_W-1:0]  data_s;
  logic               cp_s;
  logic               cs_s_n;
  logic               we_s_n;
  logic               oe_s_n;
  logic               cp_prev;
  logic               cp_rise;
  logic               write_lvl;
  logic               load_mem;
  logic               load_din;
  logic [DATA_W-1:0]  mem [WORDS];
  logic [DATA_W-1:0]  out_reg;
  logic [DATA_W-1:0]  next_out_reg;
  logic               drive_en;
  rsor_mode_e         mode;

  ////////////////////////////////////////////////////////////////////////
  // Address match used by every word and by the read mux
  function automatic logic word_hit(
    input logic [ADDR_BW-1:0] addr,
    input int unsigned        idx
  );
    logic [ADDR_BW-1:0] idx_v;
    idx_v    = ADDR_BW'(idx);
    word_hit = (addr == idx_v);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign ctrl_raw[CTRL_CP] = cp;
  assign ctrl_raw[CTRL_CS] = cs_n;
  assign ctrl_raw[CTRL_WE] = we_n;
  assign ctrl_raw[CTRL_OE] = oe_n;

  rsor_sync #(
    .WIDTH   (CTRL_W),
    .RST_VAL (CTRL_RST)
  ) u_sync_ctrl (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (ctrl_raw),
    .sync_out (ctrl_s)
  );

  rsor_sync #(
    .WIDTH   (ADDR_BW),
    .RST_VAL (ADDR_BW'(ADDR_RST))
  ) u_sync_addr (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (word_select),
    .sync_out (addr_s)
  );

  rsor_sync #(
    .WIDTH   (DATA_W),
    .RST_VAL (DATA_W'(WORD_RST))
  ) u_sync_data (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (write_data_in),
    .sync_out (data_s)
  );

  assign cp_s   = ctrl_s[CTRL_CP];
  assign cs_s_n = ctrl_s[CTRL_CS];
  assign we_s_n = ctrl_s[CTRL_WE];
  assign oe_s_n = ctrl_s[CTRL_OE];

  ////////////////////////////////////////////////////////////////////////
  // Clock pin edge detect on the synchronised copy
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cp_prev <= 1'b1;
    end else begin
      cp_prev <= cp_s;
    end
  end

  assign cp_rise = cp_s & ~cp_prev;

  ////////////////////////////////////////////////////////////////////////
  // Strobe decode
  // level write qualifier
  assign write_lvl = ~cs_s_n & ~we_s_n & ~cp_s;
  assign load_mem  = cp_rise & ~cs_s_n & we_s_n;
  assign load_din  = cp_rise & ~cs_s_n & ~we_s_n;

  ////////////////////////////////////////////////////////////////////////
  // Memory array, one process per word
  // inputs sampled each cycle, host keeps them steady
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_word
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          mem[gi] <= DATA_W'(WORD_RST);
        end else if (write_lvl && word_hit(addr_s, gi)) begin
          mem[gi] <= data_s;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Output register next value
  always_comb begin
    next_out_reg = out_reg;
    if (load_din) begin
      next_out_reg = data_s;
    end else if (load_mem) begin
      for (int i = 0; i < WORDS; i++) begin
        if (word_hit(addr_s, i)) begin
          next_out_reg = mem[i];
        end
      end
    end
  end

  // register holds unless an edge loads it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= DATA_W'(WORD_RST);
    end else begin
      out_reg <= next_out_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output buffer enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_en <= 1'b0;
    end else begin
      drive_en <= ~oe_s_n;
    end
  end

  assign read_data_out = out_reg;
  assign read_data_oe  = {DATA_W{drive_en}};

  ////////////////////////////////////////////////////////////////////////
  // Mode tracking for visibility in waves
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= RSOR_IDLE;
    end else begin
      case (mode)
        RSOR_IDLE: begin
          if (write_lvl) begin
            mode <= RSOR_WRITE;
          end else if (!cs_s_n) begin
            mode <= RSOR_HOLD;
          end
        end
        RSOR_WRITE: begin
          if (!write_lvl) begin
            mode <= cs_s_n ? RSOR_IDLE : RSOR_HOLD;
          end
        end
        RSOR_HOLD: begin
          if (write_lvl) begin
            mode <= RSOR_WRITE;
          end else if (cs_s_n) begin
            mode <= RSOR_IDLE;
          end
        end
        default: begin
          mode <= RSOR_IDLE;
        end
      endcase
    end
  end

endmodule // rsor_register_stack

// >>> rsor_pkg.sv
// Shared constants for the 16x4 register stack with output register
package rsor_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Array shape
  localparam int unsigned WORD_W = 4;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DEPTH  = 16;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;
  localparam logic [3:0]        CTRL_RST = 4'hF;

  ////////////////////////////////////////////////////////////////////////
  // Control bundle bit positions (synchronised strobes)
  localparam int unsigned CTRL_CP  = 0;
  localparam int unsigned CTRL_CS  = 1;
  localparam int unsigned CTRL_WE  = 2;
  localparam int unsigned CTRL_OE  = 3;
  localparam int unsigned CTRL_W   = 4;

  ////////////////////////////////////////////////////////////////////////
  // Synchroniser depth in cycles
  localparam int unsigned SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////
  // Operating modes tracked internally for waves
  typedef enum logic [1:0] {
    RSOR_IDLE,
    RSOR_WRITE,
    RSOR_HOLD
  } rsor_mode_e;

endpackage : rsor_pkg

// >>> rsor_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
module rsor_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // rsor_sync

// >>> rsor_register_stack_sva.sv
// Port checks for the register stack
module rsor_register_stack_sva (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       cp,
  input wire logic       cs_n,
  input wire logic       we_n,
  input wire logic       oe_n,
  input wire logic [3:0] write_data_in,
  input wire logic [3:0] read_data_out,
  input wire logic [3:0] read_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_load;
    (!cs_n && !we_n && $stable(write_data_in))[*3] ##0 $rose(cp);
  endsequence

  a_oe_on: assert property ((!oe_n)[*5] |-> read_data_oe == 4'hF)
    else $error("drive enable not raised");
  a_oe_off: assert property (oe_n[*5] |-> read_data_oe == 4'h0)
    else $error("drive enable not released");
  a_oe_whole: assert property (read_data_oe inside {4'h0, 4'hF})
    else $error("drive enable bits differ");
  a_desel_hold: assert property (cs_n[*5] |=> $stable(read_data_out))
    else $error("output changed while deselected");
  a_high_hold: assert property (cp[*5] |=> $stable(read_data_out))
    else $error("output changed without clock rise");
  a_write_hold: assert property ((!cp)[*5] |=> $stable(read_data_out))
    else $error("output changed during write");
  a_data_load: assert property (s_wr_load ##1
    (!cs_n && !we_n && cp && $stable(write_data_in))[*5]
    |-> read_data_out == write_data_in)
    else $error("write data not loaded");
  a_load_cause: assert property ($changed(read_data_out)
    |-> $past(cp) && !$past(cs_n, 3))
    else $error("output changed without selected rise");

  c_read_load: cover property ($rose(cp) && !cs_n && we_n);
  c_write_load: cover property ($rose(cp) && !cs_n && !we_n);
  c_oe_on: cover property ($fell(oe_n));
endmodule // rsor_register_stack_sva

bind rsor_register_stack rsor_register_stack_sva u_rsor_register_stack_sva (
  .mclk, .rst_n, .cp, .cs_n, .we_n, .oe_n, .write_data_in, .read_data_out,
  .read_data_oe
);

// >>> rsor_host.sv
// Host model driving the stack pins
module rsor_host (
  // Clock
  input  wire logic mclk,
  // Pins toward the stack
  output logic       cp,
  output logic       cs_n,
  output logic       we_n,
  output logic       oe_n,
  output logic [3:0] word_select,
  output logic [3:0] write_data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {cp, cs_n, we_n, oe_n, word_select, write_data_in} = {4'hF, 8'h00};
  end

  task automatic set(input logic c, w, p, input logic [3:0] a, d);
    {cs_n, we_n, cp, word_select, write_data_in} = {c, w, p, a, d};
    repeat (6) @(negedge mclk);
  endtask

  task automatic set_oe(input logic o);
    oe_n = o;
    repeat (6) @(negedge mclk);
  endtask
endmodule // rsor_host

// >>> rsor_register_stack_test.sv
// Self-checking bench for the register stack
module rsor_register_stack_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cp, cs_n, we_n, oe_n;
  logic [3:0] word_select, write_data_in, read_data_out, read_data_oe;
  int         bad_count = 0;
  int         compares = 0;

  always #5 mclk = ~mclk;

  rsor_host u_rsor_host (.mclk, .cp, .cs_n, .we_n, .oe_n, .word_select,
    .write_data_in);
  rsor_register_stack u_rsor_register_stack (.mclk, .rst_n, .cp, .cs_n,
    .we_n, .oe_n, .word_select, .write_data_in, .read_data_out,
    .read_data_oe);

  task automatic chk(input logic [3:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Drive enable compare, all four bits must agree with the expectation
  task automatic chk_oe(input logic [3:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: oe got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, d, d2);
    logic [3:0] p;
    p = read_data_out;
    u_rsor_host.set(1'b1, 1'b1, 1'b1, a, d);
    u_rsor_host.set(1'b0, 1'b0, 1'b0, a, d);
    chk(read_data_out, p);
    u_rsor_host.set(1'b0, 1'b0, 1'b0, a, d2);
    u_rsor_host.set(1'b0, 1'b0, 1'b1, a, d2);
    chk(read_data_out, d2);
    u_rsor_host.set(1'b1, 1'b1, 1'b1, a, d2);
  endtask

  task automatic rd(input logic [3:0] a, exp);
    u_rsor_host.set(1'b0, 1'b1, 1'b0, a, 4'h0);
    u_rsor_host.set(1'b0, 1'b1, 1'b1, a, 4'h0);
    chk(read_data_out, exp);
    u_rsor_host.set(1'b1, 1'b1, 1'b1, a, 4'h0);
  endtask

  task automatic t_fill();
    for (int i = 0; i < 16; i++) begin
      wr(4'(i), ~(4'(i) ^ 4'h5), 4'(i) ^ 4'h5);
    end
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), 4'(i) ^ 4'h5);
    end
  endtask

  task automatic t_desel();
    u_rsor_host.set(1'b1, 1'b0, 1'b0, 4'h2, 4'hC);
    u_rsor_host.set(1'b1, 1'b0, 1'b1, 4'h2, 4'hC);
    chk(read_data_out, 4'hA);
    rd(4'h2, 4'h7);
  endtask

  task automatic t_oe();
    u_rsor_host.set_oe(1'b0);
    chk_oe(read_data_oe, 4'hF);
    chk(read_data_out, 4'h7);
    u_rsor_host.set_oe(1'b1);
    chk_oe(read_data_oe, 4'h0);
  endtask

  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk(read_data_out, 4'h0);
    chk_oe(read_data_oe, 4'h0);
    t_fill();
    t_desel();
    t_oe();
    summarize();
  end

  // Watchdog well beyond the expected run
  initial begin
    #50us;
    bad_count++;
    summarize();
  end
endmodule // rsor_register_stack_test
